// ### hdl/sard_params.svh
// timing counts, word layout and code figures for the serial readout link
`ifndef SARD_PARAMS_SVH
`define SARD_PARAMS_SVH
`define SARD_CLK_NS 50
`define SARD_WORD_BITS 16
`define SARD_RES_BITS 10
`define SARD_LEAD_ZEROS 3
`define SARD_TAIL_ZEROS 2
`define SARD_HOLD_END_RISE 13
`define SARD_ABORT_FIRST_FALL 2
`define SARD_ABORT_LAST_FALL 10
`define SARD_TRACK_MIN_NS 350
`define SARD_QUIET_NS 50
`define SARD_FRAME_CYCLES 20
`define SARD_HALF_PERIOD 2
`define SARD_TRACK_MIN_TICKS ((`SARD_TRACK_MIN_NS + `SARD_CLK_NS - 1) / `SARD_CLK_NS)
`define SARD_QUIET_TICKS ((`SARD_QUIET_NS + `SARD_CLK_NS - 1) / `SARD_CLK_NS)
`define SARD_FULL_SCALE 1024
`endif

// ### hdl/sard_pkg.sv
// types shared by both ends of the serial readout link
`default_nettype none
package sard_pkg;
  // converter end state, gray along idle-hold-track
  typedef enum logic [1:0] {
    SARD_IDLE = 2'b00,
    SARD_HOLD = 2'b01,
    SARD_TRACK = 2'b11,
    SARD_SHUT = 2'b10
  } sard_dev_e;
  // host end state, gray along idle-low-high-gap
  typedef enum logic [1:0] {
    SARD_H_IDLE = 2'b00,
    SARD_H_LOW = 2'b01,
    SARD_H_HIGH = 2'b11,
    SARD_H_GAP = 2'b10
  } sard_host_e;
  typedef logic [9:0] sard_code_t;
endpackage
`default_nettype wire

// ### hdl/sard_if.sv
// wires between converter end and host end
`default_nettype none
interface sard_if;
  logic frame_sel_n; // low frames one conversion
  logic sclk;        // serial clock from the host
  logic result_out;  // data bit from converter
  logic result_oe_n; // low while converter drives result_out
  // converter end
  modport dev (input frame_sel_n, input sclk, output result_out, output result_oe_n);
  // host end
  modport host (output frame_sel_n, output sclk, input result_out, input result_oe_n);
endinterface
`default_nettype wire

// ### hdl/sard_dev.sv
// converter end: frame decode, track/hold, 16-bit word shift-out
// ==========================================================
// What this block and the host end do
// R1 - host frame select starts; host clock paces
// R2 - frame select fall: hold input, drive output
// R3 - back to track on 13th rising edge
// R4 - host leaves 350 ns track time
// R5 - float output after 16th fall or deselect
// R6 - host waits quiet time before next frame
// R7 - quiet time is 50 ns
// R8 - host gives sixteen clocks per word
// R9 - three zeros, ten bits MSB first, two zeros
// R10 - change on falling, capture on rising edge
// R11 - early frame may add fourth zero
// R12 - straight binary code, LSB full scale/1024
// R13 - twenty clock frame for full throughput
// R14 - frame spacing 12.5 plus track plus pad
// R15 - pad keeps whole cycles per frame
// R16 - shorter frames allowed if limits met
// R17 - deselect between falls 2 and 10: shutdown
// R18 - deselected: output floats, clock ignored
`include "sard_params.svh"
`default_nettype none
module sard_dev
  import sard_pkg::*;
#(
  parameter int RES_BITS = `SARD_RES_BITS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  sard_if.dev link,
  // analog side: sampled code from the converter core
  input wire logic [RES_BITS-1:0] sample_code,
  // status
  output logic tracking,
  output logic shutdown
);
  // ==========================================================
  // elaboration check
  initial begin
    if (RES_BITS != `SARD_RES_BITS) begin
      $error("word format only serves ten result bits");
    end
  end

  // ==========================================================
  // link edge detection, inputs taken as synchronous
  logic sel_d; // frame select one cycle ago
  logic clk_d; // serial clock one cycle ago
  logic sel_fall, sel_rise, sclk_fall, sclk_rise;
  assign sel_fall = sel_d & ~link.frame_sel_n;
  assign sel_rise = ~sel_d & link.frame_sel_n;
  assign sclk_fall = clk_d & ~link.sclk;
  assign sclk_rise = ~clk_d & link.sclk;

  // ==========================================================
  // frame state
  sard_dev_e state, next_state;
  logic [4:0] falls, next_falls;   // falling edges seen this frame
  logic [4:0] rises, next_rises;   // rising edges seen this frame
  logic [15:0] word, next_word;    // outgoing word, bit 14 leaves first
  logic oe_n, next_oe_n;           // output enable, low drives
  logic dout, next_dout;           // current bit on the pin
  logic next_tracking, next_shutdown;

  // next-state computation
  always_comb begin
    next_state = state;
    next_falls = falls;
    next_rises = rises;
    next_word = word;
    next_oe_n = oe_n;
    next_dout = dout;
    next_tracking = tracking;
    next_shutdown = shutdown;
    if (sel_fall) begin
      // sample the code; word is zeros, code, zeros [R9] [R12]
      // top bit pads the 15-bit layout to the 16-bit shifter; it is never shifted out, the frame-fall zero is set directly
      next_word = {1'b0, {`SARD_LEAD_ZEROS{1'b0}}, sample_code, {`SARD_TAIL_ZEROS{1'b0}}}; // [R9]
      next_state = SARD_HOLD;            // [R2] [R1]
      next_tracking = 1'b0;              // [R2]
      next_oe_n = 1'b0;                  // [R2]
      next_dout = 1'b0;                  // first leading zero shown at once [R11]
      next_falls = '0;
      next_rises = '0;
      next_shutdown = 1'b0;              // low frame select wakes the part
    end else if (link.frame_sel_n) begin
      // deselected: float and ignore the clock [R18]
      next_oe_n = 1'b1;                  // [R5] [R18]
      if (sel_rise) begin
        // abort window between fall 2 and fall 10 [R17]
        if (falls >= 5'(`SARD_ABORT_FIRST_FALL) && falls < 5'(`SARD_ABORT_LAST_FALL)) begin
          next_shutdown = 1'b1;          // [R17]
          next_state = SARD_SHUT;
        end else begin
          next_state = SARD_IDLE;
        end
        next_tracking = 1'b1;            // aborted conversion goes back to track
      end
    end else begin
      // frame running; clock paces conversion and shifting [R1]
      if (sclk_rise && rises != 5'h1F) begin
        next_rises = rises + 5'h01;
        if (rises == 5'(`SARD_HOLD_END_RISE - 1)) begin
          next_state = SARD_TRACK;       // [R3]
          next_tracking = 1'b1;          // [R3]
        end
      end
      if (sclk_fall && falls != 5'h1F) begin
        next_falls = falls + 5'h01;
        if (falls == 5'(`SARD_WORD_BITS - 1)) begin
          next_oe_n = 1'b1;              // 16th fall releases the pin [R5]
          next_dout = 1'b0;
        end else if (falls < 5'(`SARD_WORD_BITS - 1)) begin
          // bit changes on falling edge [R10]
          next_dout = word[4'(`SARD_WORD_BITS - 2) - falls[3:0]]; // [R10] [R9]
        end
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_d <= 1'b1;
      clk_d <= 1'b1;  // idle clock level, so no false edge follows reset
      state <= SARD_IDLE;
      falls <= '0;
      rises <= '0;
      word <= '0;
      oe_n <= 1'b1;
      dout <= 1'b0;
      tracking <= 1'b1;
      shutdown <= 1'b0;
    end else begin
      sel_d <= link.frame_sel_n;
      clk_d <= link.sclk;
      state <= next_state;
      falls <= next_falls;
      rises <= next_rises;
      word <= next_word;
      oe_n <= next_oe_n;
      dout <= next_dout;
      tracking <= next_tracking;
      shutdown <= next_shutdown;
    end
  end

  // pin outputs straight from flops
  assign link.result_out = dout;
  assign link.result_oe_n = oe_n;
endmodule
`default_nettype wire

// ### hdl/sard_host.sv
// host end: frame and clock generation, word capture through a two-entry buffer
`include "sard_params.svh"
`default_nettype none
module sard_host
  import sard_pkg::*;
#(
  parameter int FRAME_CYCLES = `SARD_FRAME_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  sard_if.host link,
  // user request
  input wire logic start,
  output logic busy,
  // result stream
  output logic code_valid,
  input wire logic code_ready,
  output logic [`SARD_RES_BITS-1:0] code
);
  localparam int GAP_TICKS = `SARD_TRACK_MIN_TICKS > `SARD_QUIET_TICKS ?
                             `SARD_TRACK_MIN_TICKS : `SARD_QUIET_TICKS;
  // ==========================================================
  // elaboration check: at least 17 clocks, at most 31 [R8] [R16]
  initial begin
    if (FRAME_CYCLES < `SARD_WORD_BITS + 1 || FRAME_CYCLES > 31 || BUF_DEPTH != 2) begin
      $error("frame length or buffer depth not served");
    end
  end

  // ==========================================================
  // frame generator
  sard_host_e state, next_state;
  logic sel_n, next_sel_n;
  logic sclk, next_sclk;
  logic ph, next_ph;                 // half-period phase within a clock cycle
  logic [4:0] cyc, next_cyc;         // serial clock cycles in this frame
  logic [4:0] gap, next_gap;         // ticks of high frame select
  logic [15:0] sh, next_sh;          // captured bits
  logic push, next_push;
  logic next_busy;                   // busy flag, registered so the output comes from a flop
  logic in_ready;                    // buffer can take a word

  always_comb begin
    next_state = state;
    next_sel_n = sel_n;
    next_sclk = sclk;
    next_ph = ph;
    next_cyc = cyc;
    next_gap = gap;
    next_sh = sh;
    next_push = 1'b0;
    case (state)
      SARD_H_IDLE: begin
        // stall on a full buffer, so no word is lost
        if (start && in_ready) begin
          next_state = SARD_H_LOW;
          next_sel_n = 1'b0;         // [R1]
          next_sclk = 1'b1;          // clock high so first edge is a fall
          next_ph = 1'b0;
          next_cyc = '0;
        end
      end
      SARD_H_LOW: begin
        next_ph = ~ph;
        if (ph) begin
          next_sclk = ~sclk;
          if (!sclk) begin
            // rising edge: capture the bit [R10]
            next_sh = {sh[14:0], link.result_out}; // [R10]
            next_cyc = cyc + 5'h01;
            if (cyc == 5'(`SARD_WORD_BITS - 1)) begin
              next_push = 1'b1;      // [R8]
            end
            if (cyc == 5'(FRAME_CYCLES - 1)) begin
              next_state = SARD_H_HIGH;
              next_sel_n = 1'b1;     // frame done, spacing met by length [R13] [R14] [R15]
              next_gap = '0;
            end
          end
        end
      end
      SARD_H_HIGH: begin
        // keep select high for track and quiet time [R4] [R6] [R7]
        next_gap = gap + 5'h01;
        if (gap == 5'(GAP_TICKS - 1)) begin
          next_state = SARD_H_GAP;
        end
      end
      SARD_H_GAP: begin
        next_state = SARD_H_IDLE;
      end
      default: begin
        next_state = SARD_H_IDLE;
      end
    endcase
    next_busy = (next_state != SARD_H_IDLE);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= SARD_H_IDLE;
      sel_n <= 1'b1;
      sclk <= 1'b1;
      ph <= 1'b0;
      cyc <= '0;
      gap <= '0;
      sh <= '0;
      push <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      sel_n <= next_sel_n;
      sclk <= next_sclk;
      ph <= next_ph;
      cyc <= next_cyc;
      gap <= next_gap;
      sh <= next_sh;
      push <= next_push;
      busy <= next_busy;
    end
  end

  assign link.frame_sel_n = sel_n;
  assign link.sclk = sclk;
  // ==========================================================
  // two-entry buffer; the code sits after three leading zeros [R9] [R11]
  logic [`SARD_RES_BITS-1:0] mem [BUF_DEPTH];
  logic [1:0] cnt, next_cnt;
  logic wp, rp, next_wp, next_rp;
  logic pop;
  logic next_valid;                  // registered valid, same cycle as the count
  logic [`SARD_RES_BITS-1:0] next_code; // head word for the next cycle
  assign in_ready = (cnt != 2'h2);
  assign pop = code_valid & code_ready;

  always_comb begin
    next_cnt = cnt;
    next_wp = wp;
    next_rp = rp;
    if (push) begin
      next_wp = ~wp;
    end
    if (pop) begin
      next_rp = ~rp;
    end
    if (push && !pop) begin
      next_cnt = cnt + 2'h1;
    end else if (pop && !push) begin
      next_cnt = cnt - 2'h1;
    end
    next_valid = (next_cnt != 2'h0);
    // head entry being written now is taken straight from the capture register
    if (push && next_rp == wp) begin
      next_code = sh[12:3]; // [R9]
    end else begin
      next_code = mem[next_rp];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      wp <= 1'b0;
      rp <= 1'b0;
      mem[0] <= '0;
      mem[1] <= '0;
      code_valid <= 1'b0;
      code <= '0;
    end else begin
      cnt <= next_cnt;
      code_valid <= next_valid;
      code <= next_code;
      wp <= next_wp;
      rp <= next_rp;
      if (push) begin
        mem[wp] <= sh[12:3]; // [R9] [R12]
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/sard_monitor.sv
// checker on the wires between converter end and host end
`default_nettype none
module sard_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link wires
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic result_out,
  input wire logic result_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // edge counts inside a frame
  logic sclk_q; // last sampled serial clock
  logic [4:0] falls; // serial clock falls since frame start
  logic [4:0] rises; // serial clock rises since frame start
  logic [7:0] trk; // ticks since 13th rise, saturates so idle never fires
  // one register group; falls and rises cleared while deselected so counts restart each frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b1;
      falls <= 5'h00;
      rises <= 5'h00;
      trk <= 8'hFF;
    end else begin
      sclk_q <= sclk;
      falls <= frame_sel_n ? 5'h00 : falls + 5'(sclk_q & ~sclk);
      rises <= frame_sel_n ? 5'h00 : rises + 5'(sclk & ~sclk_q);
      if (!frame_sel_n && sclk && !sclk_q && rises == 5'h0C) begin
        trk <= 8'h00;
      end else if (trk != 8'hFF) begin
        trk <= trk + 8'h01;
      end
    end
  end
  // ====================
  // wire relations
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_drive_on_select: assert property ($fell(frame_sel_n) |=> !result_oe_n && !result_out)
    else $error("output not driven low after frame start");
  a_drive_holds: assert property ($fell(frame_sel_n) |=> !result_oe_n [*8])
    else $error("output released early in frame");
  a_float_deselect: assert property (frame_sel_n && $past(frame_sel_n) |-> result_oe_n)
    else $error("output driven while deselected");
  a_float_after_last: assert property (!frame_sel_n && sclk_q && !sclk && falls == 5'h0F |-> ##[1:3] result_oe_n)
    else $error("output not released after 16th fall");
  a_word_zeros: assert property ($rose(sclk) && !result_oe_n && (falls < 5'h04 || falls == 5'h0E || falls == 5'h0F)
    |-> !result_out)
    else $error("leading or trailing bit not zero");
  a_change_on_fall: assert property ($changed(result_out) && !result_oe_n
    |-> ($past(sclk, 2) && !$past(sclk)) || ($past(sclk, 3) && !$past(sclk, 2)))
    else $error("data changed away from a clock fall");
  a_sixteen_clocks: assert property ($rose(frame_sel_n) |-> falls >= 5'h10)
    else $error("frame ended before sixteen clocks");
  a_track_time: assert property ($fell(frame_sel_n) |-> trk >= 8'h06)
    else $error("track time too short before next frame");
  a_quiet_gap: assert property ($rose(frame_sel_n) |-> frame_sel_n [*2])
    else $error("quiet time not kept");
  a_clock_high_start: assert property ($fell(frame_sel_n) |-> sclk)
    else $error("frame started with clock low");
  // main scenarios
  c_frame: cover property ($fell(frame_sel_n));
  c_last_fall: cover property (sclk_q && !sclk && falls == 5'h0F);
  c_frame_end: cover property ($rose(frame_sel_n));
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the converter and host ends
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ====================
  // signals
  logic clk_sys, rst_n, start, busy, code_valid, code_ready;
  logic tracking, shutdown, ab_trk, ab_shut;
  logic [9:0] sample_code, code;
  int error_cnt, compares;
  logic [9:0] codes [5] = '{10'h000, 10'h3FF, 10'h200, 10'h001, 10'h2AA};
  int ab_n [5] = '{1, 2, 5, 10, 12};
  logic ab_exp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  sard_if link_if();
  sard_if abort_if();
  sard_dev sard_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if.dev), .sample_code(sample_code),
    .tracking(tracking), .shutdown(shutdown));
  sard_host sard_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if.host), .start(start),
    .busy(busy), .code_valid(code_valid), .code_ready(code_ready), .code(code));
  // second converter end faces a bench driver that aborts frames on purpose
  if (1) begin : abort_side
    sard_dev sard_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(abort_if.dev), .sample_code(sample_code),
      .tracking(ab_trk), .shutdown(ab_shut));
  end
  sard_monitor sard_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n), .frame_sel_n(link_if.frame_sel_n),
    .sclk(link_if.sclk), .result_out(link_if.result_out), .result_oe_n(link_if.result_oe_n));
  // ====================
  // tasks
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one frame through the host; start held only until the frame is under way
  task automatic convert(input logic [9:0] c);
    @(negedge clk_sys);
    sample_code = c;
    start = 1'b1;
    for (int i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clk_sys);
    start = 1'b0;
    repeat (30) @(negedge clk_sys);
    chk("tracking mid", 10'h000, {9'h000, tracking});
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_sys);
    chk("tracking end", 10'h001, {9'h000, tracking});
  endtask
  // ready left high between back to back pops
  task automatic pop(input logic [9:0] c, input logic last);
    for (int i = 0; i < 50 && code_valid !== 1'b1; i++) @(negedge clk_sys);
    chk("code", c, code);
    code_ready = 1'b1;
    @(negedge clk_sys);
    if (last) code_ready = 1'b0;
  endtask
  // bench plays a host that drops select after n clock falls
  task automatic abort_frame(input int n, input logic exp);
    abort_if.frame_sel_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    repeat (n) begin
      abort_if.sclk = 1'b0;
      repeat (2) @(negedge clk_sys);
      abort_if.sclk = 1'b1;
      repeat (2) @(negedge clk_sys);
    end
    chk("oe in frame", 10'h000, {9'h000, abort_if.result_oe_n});
    abort_if.frame_sel_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("oe after rise", 10'h001, {9'h000, abort_if.result_oe_n});
    chk("shutdown", {9'h000, exp}, {9'h000, ab_shut});
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ====================
  // clock, watchdog and tests
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // whole run is some one thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    code_ready = 1'b0;
    sample_code = 10'h000;
    abort_if.frame_sel_n = 1'b1;
    abort_if.sclk = 1'b1;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    // range ends, single-bit patterns and an alternating pattern
    foreach (codes[i]) begin
      convert(codes[i]);
      pop(codes[i], 1'b1);
    end
    // two words fill the buffer, a third request must wait
    convert(10'h2AA);
    convert(10'h155);
    start = 1'b1;
    repeat (120) @(negedge clk_sys);
    chk("held frame", 10'h001, {9'h000, link_if.frame_sel_n});
    start = 1'b0;
    pop(10'h2AA, 1'b0);
    pop(10'h155, 1'b1);
    chk("drained", 10'h000, {9'h000, code_valid});
    chk("link shutdown", 10'h000, {9'h000, shutdown});
    foreach (ab_n[i]) abort_frame(ab_n[i], ab_exp[i]);
    // clock runs while deselected
    repeat (4) begin
      abort_if.sclk = ~abort_if.sclk;
      repeat (2) @(negedge clk_sys);
      chk("float idle", 10'h001, {9'h000, abort_if.result_oe_n});
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
